//--- secure_cfg_pkg.sv
// Shared constants and types of the secure configuration gate
package secure_cfg_pkg;

    // Stream and key widths
    localparam int WORD_W    = 32;
    localparam int KEY_W     = 256;
    localparam int HASH_W    = 256;
    localparam int RSA_W     = 4096;
    localparam int PK_WORDS  = RSA_W / WORD_W;
    localparam int ADDR_W    = 7;
    localparam int IR_W      = 5;

    // Index of the last word of the public key and of the signature
    localparam logic [ADDR_W-1:0] LAST_IDX = 7'h7f;

    // Header word field positions
    localparam int HDR_COMP_BIT = 0;
    localparam int HDR_ENC_BIT  = 1;
    localparam int HDR_AUTH_BIT = 2;

    // Instruction codes still honoured once test access is locked
    localparam logic [IR_W-1:0] IR_IDCODE = 5'h03;
    localparam logic [IR_W-1:0] IR_STATUS = 5'h05;
    localparam logic [IR_W-1:0] IR_BYPASS = 5'h1f;

    // Reset value of the fuse settle shift register
    localparam logic [1:0] SETTLE_RST = 2'h0;

    // Kind of word sent to the signature engine
    typedef enum logic [1:0] {
        KIND_KEY = 2'h0,
        KIND_SIG = 2'h1,
        KIND_MSG = 2'h2
    } rsa_kind_t;

    // Reason for halting configuration
    typedef enum logic [2:0] {
        ERR_NONE     = 3'h0,
        ERR_COMPRESS = 3'h1,
        ERR_KEY_HASH = 3'h2,
        ERR_TAG      = 3'h3,
        ERR_SIG      = 3'h4
    } err_t;

    // Loader phases
    typedef enum logic [3:0] {
        S_HEADER  = 4'h0,
        S_PKEY    = 4'h1,
        S_HASH    = 4'h2,
        S_SIG     = 4'h3,
        S_BODY    = 4'h4,
        S_TAG     = 4'h5,
        S_KEYLOAD = 4'h6,
        S_VERDICT = 4'h7,
        S_USER    = 4'h8,
        S_HALT    = 4'h9
    } state_t;

endpackage

//--- pk_mem_if.sv
// Port bundle between the loader and its public key store
interface pk_mem_if;
    import secure_cfg_pkg::*;

    logic                  wr_en;
    logic [ADDR_W-1:0]     wr_addr;
    logic [WORD_W-1:0]     wr_data;
    logic                  rd_en;
    logic [ADDR_W-1:0]     rd_addr;
    logic [WORD_W-1:0]     rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output rd_data);
endinterface

//--- pk_store.sv
// Public key word store with registered read data
module pk_store import secure_cfg_pkg::*; (
    input  wire logic  clk_i,
    pk_mem_if.mem      bus
);

    logic [WORD_W-1:0] mem_q [PK_WORDS];
    logic [WORD_W-1:0] rd_data_q;

    // Write port
    always_ff @(posedge clk_i) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Read port, data held until the next read
    always_ff @(posedge clk_i) begin
        if (bus.rd_en) begin
            rd_data_q <= mem_q[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_data_q;

endmodule // pk_store

//--- jtag_gate.sv
// Test access instruction filter driven by the lock fuse
module jtag_gate import secure_cfg_pkg::*; (
    input  wire logic            clk_i,
    input  wire logic            srst_i,
    input  wire logic            block_fuse_i,
    input  wire logic            ir_valid_i,
    input  wire logic [IR_W-1:0] ir_code_i,
    output logic                 ir_valid_o,
    output logic      [IR_W-1:0] ir_code_o,
    output logic                 refused_o
);

    logic            meta_q;
    logic            sync_q;
    logic            blocked_q;
    logic [1:0]      settle_q;
    logic            allowed;
    logic            lock;
    logic            ir_valid_q;
    logic [IR_W-1:0] ir_code_q;
    logic            refused_q;

    // Two-stage synchroniser on the fuse sense line
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= block_fuse_i;
            sync_q <= meta_q;
        end
    end

    // Lock is sticky; only a new fuse sense at reset re-evaluates it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            blocked_q <= 1'b0;
            settle_q  <= SETTLE_RST;
        end else begin
            blocked_q <= blocked_q | sync_q;
            settle_q  <= {settle_q[0], 1'b1};
        end
    end

    // Treat as locked until the fuse sense has passed the synchroniser
    assign lock    = blocked_q | sync_q | ~settle_q[1];
    assign allowed = (ir_code_i == IR_IDCODE) || (ir_code_i == IR_STATUS)
                  || (ir_code_i == IR_BYPASS);

    // Refused instructions are replaced by bypass
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ir_valid_q <= 1'b0;
            ir_code_q  <= IR_BYPASS;
            refused_q  <= 1'b0;
        end else begin
            ir_valid_q <= ir_valid_i;
            refused_q  <= ir_valid_i & lock & ~allowed;
            if (ir_valid_i) begin
                ir_code_q <= (lock && !allowed) ? IR_BYPASS : ir_code_i;
            end
        end
    end

    assign ir_valid_o = ir_valid_q;
    assign ir_code_o  = ir_code_q;
    assign refused_o  = refused_q;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    refuse_locked_a: assert property (
        ir_valid_i && lock && !allowed
        |=> refused_o && ir_code_o == IR_BYPASS)
        else $error("locked instruction not refused");

    pass_allowed_a: assert property (
        ir_valid_i && allowed |=> !refused_o && ir_code_o == $past(ir_code_i))
        else $error("allowed instruction altered");

    lock_sticky_a: assert property (
        blocked_q |=> blocked_q [*8])
        else $error("test access lock lifted");

endmodule // jtag_gate

//--- secure_cfg_gate.sv
// Secure configuration loader: header check, key hash, decrypt, signature
////////////////////////////////////////////////////////////////////////

// Overview of operation
// - Compressed images with decryption or signature checking are rejected.
// - Decryption and signature checking are enabled separately per image.
// - The 256-bit cipher key comes from one-time fuses.
// - Encrypted body goes through the cipher engine; bad tag halts loading.
// - With authentication on, a 4096-bit key checks the image signature.
// - Image carries public key and signature; fuses only hold key hash.
// - A valid signature lets loading finish and user mode start.
// - An invalid signature halts loading with user mode kept off.
// - Locked test access only allows identity, status and bypass.
// - Test access lock is permanent once the fuse is blown.
module secure_cfg_gate import secure_cfg_pkg::*; (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // Incoming image stream
    input  wire logic              in_valid_i,
    input  wire logic [WORD_W-1:0] in_data_i,
    input  wire logic              in_last_i,
    output logic                   in_ready_o,
    // Fuse contents
    input  wire logic [KEY_W-1:0]  fuse_key_i,
    input  wire logic [HASH_W-1:0] fuse_pk_hash_i,
    input  wire logic              jtag_block_fuse_i,
    // Test access instruction path
    input  wire logic              jtag_ir_valid_i,
    input  wire logic [IR_W-1:0]   jtag_ir_code_i,
    output logic                   jtag_ir_valid_o,
    output logic      [IR_W-1:0]   jtag_ir_code_o,
    output logic                   jtag_refused_o,
    // Cipher engine
    output logic      [KEY_W-1:0]  aes_key_o,
    output logic                   aes_in_valid_o,
    output logic      [WORD_W-1:0] aes_in_data_o,
    input  wire logic              aes_in_ready_i,
    input  wire logic              aes_out_valid_i,
    input  wire logic [WORD_W-1:0] aes_out_data_i,
    input  wire logic              aes_done_i,
    input  wire logic              aes_tag_ok_i,
    // Hash engine
    output logic                   hash_valid_o,
    output logic      [WORD_W-1:0] hash_data_o,
    output logic                   hash_last_o,
    input  wire logic              hash_ready_i,
    input  wire logic              hash_done_i,
    input  wire logic [HASH_W-1:0] hash_digest_i,
    // Signature engine
    output logic                   rsa_valid_o,
    output rsa_kind_t              rsa_kind_o,
    output logic      [WORD_W-1:0] rsa_data_o,
    input  wire logic              rsa_ready_i,
    output logic                   rsa_check_o,
    input  wire logic              rsa_done_i,
    input  wire logic              rsa_ok_i,
    // Toward the configuration memory and status
    output logic                   cfg_out_valid_o,
    output logic      [WORD_W-1:0] cfg_out_data_o,
    output logic                   user_mode_o,
    output logic                   cfg_halt_o,
    output err_t                   cfg_err_o
);

    state_t            state_q;
    state_t            state_d;
    err_t              err_q;
    err_t              err_d;
    logic              enc_q;
    logic              auth_q;
    logic [ADDR_W-1:0] wcnt_q;
    logic [ADDR_W-1:0] raddr_q;
    logic              rd_pend_q;
    logic              rd_done_q;
    logic              out_valid_q;
    logic [WORD_W-1:0] out_data_q;
    logic              in_fire;
    logic              hdr_fire;
    logic              body_fire;
    logic              hdr_comp;
    logic              hdr_enc;
    logic              hdr_auth;
    logic              rd_issue;
    logic              keyload_end;

    pk_mem_if mem_bus ();

    pk_store u_pk_store (
        .clk_i (clk_i),
        .bus   (mem_bus)
    );

    jtag_gate u_jtag_gate (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .block_fuse_i (jtag_block_fuse_i),
        .ir_valid_i   (jtag_ir_valid_i),
        .ir_code_i    (jtag_ir_code_i),
        .ir_valid_o   (jtag_ir_valid_o),
        .ir_code_o    (jtag_ir_code_o),
        .refused_o    (jtag_refused_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Header fields
    assign hdr_comp = in_data_i[HDR_COMP_BIT];
    assign hdr_enc  = in_data_i[HDR_ENC_BIT];
    assign hdr_auth = in_data_i[HDR_AUTH_BIT];

    // Stream acceptance; body waits for every engine that needs the word
    always_comb begin
        case (state_q)
            S_HEADER: in_ready_o = 1'b1;
            S_PKEY:   in_ready_o = hash_ready_i;
            S_SIG:    in_ready_o = rsa_ready_i;
            S_BODY:   in_ready_o = (!enc_q || aes_in_ready_i)
                                && (!auth_q || rsa_ready_i);
            default:  in_ready_o = 1'b0;
        endcase
    end

    assign in_fire   = in_valid_i && in_ready_o;
    assign hdr_fire  = in_fire && (state_q == S_HEADER);
    assign body_fire = in_fire && (state_q == S_BODY);

    ////////////////////////////////////////////////////////////////////
    // Next phase and halt reason
    always_comb begin
        state_d = state_q;
        err_d   = ERR_NONE;
        case (state_q)
            S_HEADER: begin
                if (hdr_fire) begin
                    if (hdr_comp && (hdr_enc || hdr_auth)) begin
                        state_d = S_HALT;
                        err_d   = ERR_COMPRESS;
                    end else if (hdr_auth) begin
                        state_d = S_PKEY;
                    end else begin
                        state_d = S_BODY;
                    end
                end
            end
            S_PKEY: begin
                if (in_fire && wcnt_q == LAST_IDX) begin
                    state_d = S_HASH;
                end
            end
            S_HASH: begin
                if (hash_done_i) begin
                    if (hash_digest_i == fuse_pk_hash_i) begin
                        state_d = S_SIG;
                    end else begin
                        state_d = S_HALT;
                        err_d   = ERR_KEY_HASH;
                    end
                end
            end
            S_SIG: begin
                if (in_fire && wcnt_q == LAST_IDX) begin
                    state_d = S_BODY;
                end
            end
            S_BODY: begin
                if (body_fire && in_last_i) begin
                    if (enc_q) begin
                        state_d = S_TAG;
                    end else if (auth_q) begin
                        state_d = S_KEYLOAD;
                    end else begin
                        state_d = S_USER;
                    end
                end
            end
            S_TAG: begin
                if (aes_done_i) begin
                    if (!aes_tag_ok_i) begin
                        state_d = S_HALT;
                        err_d   = ERR_TAG;
                    end else if (auth_q) begin
                        state_d = S_KEYLOAD;
                    end else begin
                        state_d = S_USER;
                    end
                end
            end
            S_KEYLOAD: begin
                if (keyload_end) begin
                    state_d = S_VERDICT;
                end
            end
            S_VERDICT: begin
                if (rsa_done_i) begin
                    if (rsa_ok_i) begin
                        state_d = S_USER;
                    end else begin
                        state_d = S_HALT;
                        err_d   = ERR_SIG;
                    end
                end
            end
            default: state_d = state_q;
        endcase
    end

    // Phase register; user mode and halt are terminal until reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= S_HEADER;
        end else begin
            state_q <= state_d;
        end
    end

    // Halt reason captured on entry to halt
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            err_q <= ERR_NONE;
        end else if (state_d == S_HALT && state_q != S_HALT) begin
            err_q <= err_d;
        end
    end

    // Per-image security options, taken from the header word
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            enc_q  <= 1'b0;
            auth_q <= 1'b0;
        end else if (hdr_fire) begin
            enc_q  <= hdr_enc;
            auth_q <= hdr_auth;
        end
    end

    // Word counter for the key and signature phases
    always_ff @(posedge clk_i) begin
        if (srst_i || state_d != state_q) begin
            wcnt_q <= '0;
        end else if (in_fire) begin
            wcnt_q <= wcnt_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Image public key goes to the hash engine and to the key store
    assign hash_valid_o    = in_valid_i && (state_q == S_PKEY);
    assign hash_data_o     = in_data_i;
    assign hash_last_o     = (wcnt_q == LAST_IDX);
    assign mem_bus.wr_en   = in_fire && (state_q == S_PKEY);
    assign mem_bus.wr_addr = wcnt_q;
    assign mem_bus.wr_data = in_data_i;

    // Cipher engine always holds the fuse key, never the image
    assign aes_key_o      = fuse_key_i;
    assign aes_in_valid_o = in_valid_i && (state_q == S_BODY) && enc_q
                         && (!auth_q || rsa_ready_i);
    assign aes_in_data_o  = in_data_i;

    ////////////////////////////////////////////////////////////////////
    // Key replay: only loaded after its hash matched the fuses
    assign rd_issue        = (state_q == S_KEYLOAD) && !rd_done_q
                          && (!rd_pend_q || rsa_ready_i);
    assign mem_bus.rd_en   = rd_issue;
    assign mem_bus.rd_addr = raddr_q;
    assign keyload_end     = (state_q == S_KEYLOAD) && rd_done_q
                          && (!rd_pend_q || rsa_ready_i);
    assign rsa_check_o     = keyload_end;

    // Replay read pointer and pending word
    always_ff @(posedge clk_i) begin
        if (srst_i || state_q != S_KEYLOAD) begin
            raddr_q   <= '0;
            rd_done_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            if (rd_issue) begin
                raddr_q <= raddr_q + 7'h01;
            end
            if (rd_issue && raddr_q == LAST_IDX) begin
                rd_done_q <= 1'b1;
            end
            rd_pend_q <= rd_issue || (rd_pend_q && !rsa_ready_i);
        end
    end

    // Signature engine word source per phase
    always_comb begin
        rsa_valid_o = 1'b0;
        rsa_kind_o  = KIND_MSG;
        rsa_data_o  = in_data_i;
        case (state_q)
            S_SIG: begin
                rsa_valid_o = in_valid_i;
                rsa_kind_o  = KIND_SIG;
            end
            S_BODY: begin
                rsa_valid_o = in_valid_i && auth_q
                           && (!enc_q || aes_in_ready_i);
            end
            S_KEYLOAD: begin
                rsa_valid_o = rd_pend_q;
                rsa_kind_o  = KIND_KEY;
                rsa_data_o  = mem_bus.rd_data;
            end
            default: rsa_valid_o = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration words: plaintext body or cipher engine output
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            out_valid_q <= 1'b0;
            if (enc_q && aes_out_valid_i) begin
                out_valid_q <= 1'b1;
                out_data_q  <= aes_out_data_i;
            end else if (!enc_q && body_fire) begin
                out_valid_q <= 1'b1;
                out_data_q  <= in_data_i;
            end
        end
    end

    assign cfg_out_valid_o = out_valid_q;
    assign cfg_out_data_o  = out_data_q;
    assign user_mode_o     = (state_q == S_USER);
    assign cfg_halt_o      = (state_q == S_HALT);
    assign cfg_err_o       = err_q;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence bad_verdict_s;
        state_q == S_VERDICT && rsa_done_i && !rsa_ok_i;
    endsequence

    sequence halted_s;
        cfg_halt_o && !user_mode_o && cfg_err_o == ERR_SIG;
    endsequence

    compress_excl_a: assert property (
        hdr_fire && hdr_comp && (hdr_enc || hdr_auth)
        |=> cfg_halt_o && cfg_err_o == ERR_COMPRESS)
        else $error("compressed secure image not rejected");

    auth_only_a: assert property (
        hdr_fire && !hdr_comp && hdr_auth |=> state_q == S_PKEY)
        else $error("signature option did not start key phase");

    fuse_key_a: assert property (
        aes_in_valid_o |-> aes_key_o == fuse_key_i)
        else $error("cipher key not from fuses");

    decrypt_route_a: assert property (
        enc_q && aes_out_valid_i
        |=> cfg_out_valid_o && cfg_out_data_o == $past(aes_out_data_i))
        else $error("decrypted word not forwarded");

    sig_feed_a: assert property (
        in_fire && state_q == S_SIG
        |-> rsa_valid_o && rsa_kind_o == KIND_SIG)
        else $error("signature word not sent to engine");

    key_capture_a: assert property (
        in_fire && state_q == S_PKEY |-> hash_valid_o && mem_bus.wr_en)
        else $error("public key word not hashed and stored");

    good_sig_a: assert property (
        state_q == S_VERDICT && rsa_done_i && rsa_ok_i
        |=> user_mode_o [*4])
        else $error("valid signature did not reach user mode");

    bad_sig_a: assert property (
        bad_verdict_s |=> halted_s [*4] ##1 !in_ready_o)
        else $error("invalid signature did not halt");

    key_hash_a: assert property (
        state_q == S_HASH && hash_done_i
        && hash_digest_i != fuse_pk_hash_i
        |=> cfg_halt_o && cfg_err_o == ERR_KEY_HASH)
        else $error("key hash mismatch not treated as invalid");

    no_user_unchecked_a: assert property (
        $rose(user_mode_o) && auth_q |-> $past(rsa_ok_i && rsa_done_i))
        else $error("user mode without signature verdict");

endmodule // secure_cfg_gate

//--- engine_model.sv
// Behavioural hash and signature engines facing the gate
module engine_model import secure_cfg_pkg::*; (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic [HASH_W-1:0] digest_i,
    input  wire logic              sig_ok_i,
    input  wire logic              hash_valid_i,
    input  wire logic              hash_last_i,
    output logic                   hash_ready_o,
    output logic                   hash_done_o,
    output logic      [HASH_W-1:0] hash_digest_o,
    input  wire logic              rsa_check_i,
    output logic                   rsa_ready_o,
    output logic                   rsa_done_o,
    output logic                   rsa_ok_o,
    input  wire logic              aes_valid_i,
    input  wire logic [WORD_W-1:0] aes_data_i,
    output logic                   aes_valid_o,
    output logic      [WORD_W-1:0] aes_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stall_q;
    logic [3:0] hwait_q;
    logic [3:0] rwait_q;

    // Ready lines stall on a fixed pattern to exercise backpressure
    assign hash_ready_o = stall_q[0] | stall_q[2];
    assign rsa_ready_o  = stall_q[1] | stall_q[3];
    // Results are valid only with their done pulse, inverted otherwise
    assign hash_done_o   = (hwait_q == 4'h1);
    assign hash_digest_o = hash_done_o ? digest_i : ~digest_i;
    assign rsa_done_o    = (rwait_q == 4'h1);
    assign rsa_ok_o      = rsa_done_o ? sig_ok_i : ~sig_ok_i;

    // Verdict delays after the last key word and the check request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stall_q <= 4'h0;
            hwait_q <= 4'h0;
            rwait_q <= 4'h0;
        end else begin
            stall_q <= stall_q + 4'h1;
            if (hash_valid_i && hash_ready_o && hash_last_i) begin
                hwait_q <= 4'h3;
            end else if (hwait_q != 4'h0) begin
                hwait_q <= hwait_q - 4'h1;
            end
            if (rsa_check_i) begin
                rwait_q <= 4'h5;
            end else if (rwait_q != 4'h0) begin
                rwait_q <= rwait_q - 4'h1;
            end
        end
    end

    // Cipher stand-in: each word comes back inverted one cycle later
    always_ff @(posedge clk_i) begin
        aes_valid_o <= aes_valid_i && !srst_i;
        aes_data_o  <= ~aes_data_i;
    end
endmodule // engine_model

//--- secure_bitstream_config_gate_tb.sv
// Self-checking bench of the secure configuration gate
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module secure_bitstream_config_gate_tb import secure_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, srst_i = 1, v = 0, last = 0, lock = 0, jv = 0, ok = 1;
    logic [WORD_W-1:0] d = '0;
    logic [IR_W-1:0] jc = '0;
    logic [KEY_W-1:0] key = '0, ak;
    logic [HASH_W-1:0] dig = '0;
    logic [HASH_W-1:0] fhash = {8{32'h5a5a_0f0f}};
    logic in_ready_o, jv_o, jref_o, hv, hl, hr, hd, rv, rr, rc, rd, rok;
    logic cv, um, hlt, ai, av;
    logic [IR_W-1:0] jc_o;
    logic [WORD_W-1:0] hdat, cd, adi, ad, ew;
    logic [HASH_W-1:0] hdig;
    err_t err;
    int num_errors = 0, num_checks = 0, seed;
    logic [WORD_W-1:0] exp_q[$];

    always #20 clk_i = ~clk_i;

    secure_cfg_gate u_dut (.clk_i(clk_i), .srst_i(srst_i), .in_valid_i(v),
        .in_data_i(d), .in_last_i(last), .in_ready_o(in_ready_o),
        .fuse_key_i(key), .fuse_pk_hash_i(fhash), .jtag_block_fuse_i(lock),
        .jtag_ir_valid_i(jv), .jtag_ir_code_i(jc), .jtag_ir_valid_o(jv_o),
        .jtag_ir_code_o(jc_o), .jtag_refused_o(jref_o), .aes_key_o(ak),
        .aes_in_valid_o(ai), .aes_in_data_o(adi), .aes_in_ready_i(1'b1),
        .aes_out_valid_i(av), .aes_out_data_i(ad),
        .aes_done_i(av), .aes_tag_ok_i(ok), .hash_valid_o(hv),
        .hash_data_o(hdat), .hash_last_o(hl), .hash_ready_i(hr),
        .hash_done_i(hd), .hash_digest_i(hdig), .rsa_valid_o(rv),
        .rsa_kind_o(), .rsa_data_o(), .rsa_ready_i(rr), .rsa_check_o(rc),
        .rsa_done_i(rd), .rsa_ok_i(rok), .cfg_out_valid_o(cv),
        .cfg_out_data_o(cd), .user_mode_o(um), .cfg_halt_o(hlt),
        .cfg_err_o(err));
    engine_model u_eng (.clk_i(clk_i), .srst_i(srst_i), .digest_i(dig),
        .sig_ok_i(ok), .hash_valid_i(hv), .hash_last_i(hl),
        .hash_ready_o(hr), .hash_done_o(hd), .hash_digest_o(hdig),
        .rsa_check_i(rc), .rsa_ready_o(rr), .rsa_done_o(rd), .rsa_ok_o(rok),
        .aes_valid_i(ai), .aes_data_i(adi),
        .aes_valid_o(av), .aes_data_o(ad));

    ////////////////////////////////////////////////////////////////////
    // Forwarded body words match the bench queue in order
    always @(negedge clk_i) if (!srst_i && cv === 1'b1) begin
        if (exp_q.size() == 0) `CHK(cv, 1'b0)
        else begin
            ew = exp_q.pop_front();
            `CHK(cd, ew)
        end
    end

    // Report counts and end the run
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Offer one word and hold it until taken
    task automatic put(input logic [WORD_W-1:0] w, input logic l);
        int n;
        v = 1; d = w; last = l;
        for (n = 0; n < 100 && in_ready_o !== 1'b1; n++) @(negedge clk_i);
        if (n == 100) begin num_errors++; give_verdict(); end
        @(negedge clk_i);
    endtask

    // Load one image and compare the final mode and error code
    task automatic image(input logic [2:0] h, input int nb, input logic good,
                         input logic sok, input logic eu, input err_t ee);
        int n;
        logic [WORD_W-1:0] w;
        srst_i = 1; dig = good ? fhash : ~fhash; ok = sok; exp_q = {};
        repeat (10) @(negedge clk_i);
        srst_i = 0;
        put({29'h0, h}, 1'b0);
        if (!(h[0] && h[2:1] != 2'h0)) begin
            if (h[2]) for (n = 0; n < 2 * PK_WORDS; n++) begin
                if (n == PK_WORDS && !good) break;
                put($urandom, 1'b0);
            end
            if (!h[2] || good) for (n = 0; n < nb; n++) begin
                w = $urandom;
                exp_q.push_back(h[1] ? ~w : w);
                put(w, n == nb - 1);
            end
        end
        v = 0;
        for (n = 0; n < 2000 && um !== 1'b1 && hlt !== 1'b1; n++)
            @(negedge clk_i);
        if (n == 2000) begin num_errors++; give_verdict(); end
        repeat (2) @(negedge clk_i);
        `CHK(ak, key)
        `CHK(um, eu)
        `CHK(hlt, !eu)
        `CHK(err, ee)
        `CHK(exp_q.size(), 0)
    endtask

    // Issue one instruction and check the filtered result
    task automatic jt(input logic [IR_W-1:0] c, input logic locked);
        logic keep;
        keep = !locked || c == IR_IDCODE || c == IR_STATUS || c == IR_BYPASS;
        jv = 1; jc = c;
        @(negedge clk_i);
        `CHK(jv_o, 1'b1)
        `CHK(jc_o, keep ? c : IR_BYPASS)
        `CHK(jref_o, !keep)
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(12);
        key = {8{$urandom}};
        image(3'h0, 5, 1, 1, 1, ERR_NONE);
        image(3'h2, 4, 1, 1, 1, ERR_NONE);
        image(3'h2, 2, 1, 0, 0, ERR_TAG);
        image(3'h6, 3, 1, 1, 1, ERR_NONE);
        image(3'h3, 0, 1, 1, 0, ERR_COMPRESS);
        image(3'h5, 0, 1, 1, 0, ERR_COMPRESS);
        image(3'h7, 0, 1, 1, 0, ERR_COMPRESS);
        image(3'h4, 4, 1, 1, 1, ERR_NONE);
        image(3'h4, 3, 1, 0, 0, ERR_SIG);
        image(3'h4, 0, 0, 1, 0, ERR_KEY_HASH);
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 32; i++) jt(i[IR_W-1:0], 1'b0);
        // Fuse burn stand-in: stream and test access idle
        jv = 0;
        lock = 1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 32; i++) jt(i[IR_W-1:0], 1'b1);
        lock = 0;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 32; i++) jt(i[IR_W-1:0], 1'b1);
        // Reset with the fuse blown: lock holds from the first edge on
        lock = 1;
        srst_i = 1;
        repeat (2) @(negedge clk_i);
        srst_i = 0;
        for (int i = 0; i < 32; i++) jt(i[IR_W-1:0], 1'b1);
        jv = 0;
        give_verdict();
    end
endmodule // secure_bitstream_config_gate_tb
